//--- verilog/rfid_protocol_option_registers.sv
// Type A option, receive mirror, FIFO watermark and low field level registers
//
// Contract
// - With the parity-off bit set, parity errors of received Type A frames are not reported.
// - The slot-grid bit picks an 18.88 us (0) or 37.77 us (1) grid for the next-slot timer.
// - With the direct bit-stream bit set, the encoder takes host bit-stream data, not FIFO data.
// - The nibble-receive bit selects byte reception (0) or 4-bit reply reception (1).
// - The framing bit selects anticollision framing with broken bytes (0) or whole bytes (1).
// - The collision-pulse bit selects seven (0) or six (1) subcarrier pulses for a collision.
// - Bit 0 of the receive-start mirror register reads the receive-start flag.
// - The receive-start flag rises at start of frame, holds during reception, and completion pulses.
// - During reception the FIFO interrupt fires at 124, 120, 112 or 96 bytes per the high code.
// - During transmission the FIFO interrupt fires at 4, 8, 16 or 32 bytes per the low code.
// - The watermark and low field level registers reset to 0x00 at reset and while enable is low.
// - The clock-extract-off bit disables the clock extractor.
// - The collision-avoidance level sets the low comparator threshold, whose output is driven out.
module rfid_protocol_option_registers
   import rfid_opt_pkg::*;
#(
   parameter int SLOT_SHORT_CYCLES = rfid_opt_pkg::SLOT_GRID_SHORT_CYC,
   parameter int SLOT_LONG_CYCLES  = rfid_opt_pkg::SLOT_GRID_LONG_CYC
) (
   // Clock and reset
   input  wire logic                      i_sys_clk,
   input  wire logic                      i_nrst,
   // Chip enable pin
   input  wire logic                      i_en,
   // Host register port
   input  wire logic [7:0]                i_reg_addr,
   input  wire logic [7:0]                i_reg_wdata,
   input  wire logic                      i_reg_wr,
   input  wire logic                      i_reg_rd,
   output      logic [7:0]                o_reg_rdata,
   output      logic                      o_reg_rvalid,
   // Type A receive and transmit path
   input  wire logic                      i_rx_parity_err,
   input  wire logic                      i_bitstream_bit,
   input  wire logic                      i_fifo_tx_bit,
   output      logic                      o_encoder_bit,
   output      logic                      o_parity_error,
   output      logic                      o_parity_check_off,
   output      logic                      o_bitstream_direct,
   output      logic                      o_nibble_rx,
   output      logic                      o_normal_framing,
   output      logic [2:0]                o_collision_pulses,
   // Next-slot timer
   input  wire logic                      i_slot_timer_run,
   output      logic                      o_slot_grid_long,
   output      logic                      o_slot_tick,
   // Receive progress
   input  wire logic                      i_rx_sof,
   input  wire logic                      i_rx_done,
   output      logic                      o_rx_start_flag,
   output      logic                      o_rx_done_irq,
   // FIFO status
   input  wire rfid_opt_pkg::fifo_level_t i_fifo_level,
   input  wire logic                      i_rx_active,
   input  wire logic                      i_tx_active,
   output      logic                      o_fifo_irq,
   // RF field detection
   input  wire rfid_opt_pkg::ca_level_t   i_rf_field_code,
   output      logic                      o_rf_low_above,
   output      logic                      o_clock_extract_en
);
   import rfid_opt_pkg::*;

   localparam logic [SLOT_CNT_WIDTH-1:0] SLOT_SHORT_LAST =
      SLOT_CNT_WIDTH'(SLOT_SHORT_CYCLES - 1);
   localparam logic [SLOT_CNT_WIDTH-1:0] SLOT_LONG_LAST =
      SLOT_CNT_WIDTH'(SLOT_LONG_CYCLES - 1);

   typedef struct packed {
      logic [TYPE_A_WIDTH-1:0]    type_a_opts;
      logic [WATERMARK_WIDTH-1:0] watermarks;
      logic                       clock_extract_off;
      ca_level_t                  collision_avoid_level;
      logic                       en_meta;
      logic                       en_sync;
      ca_level_t                  rf_meta;
      ca_level_t                  rf_sync;
      logic [7:0]                 rdata;
      logic                       rvalid;
      logic                       encoder_bit;
      logic                       parity_error;
      logic [2:0]                 collision_pulses;
      logic                       rf_low_above;
      logic                       clock_extract_en;
      logic [SLOT_CNT_WIDTH-1:0]  slot_cnt;
      logic                       slot_tick;
   } state_t;

   state_t state_r;
   state_t state_nxt;

   option_link_if link ();

   // Helpers working on the shared link
   fifo_watermark_check u_watermark (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .link      (link.wm)
   );

   rx_start_tracker u_rx_start (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .link      (link.rs)
   );

   assign link.fifo_high_code = state_r.watermarks[FIFO_HIGH_LSB +: 2];
   assign link.fifo_low_code  = state_r.watermarks[FIFO_LOW_LSB +: 2];
   assign link.fifo_level     = i_fifo_level;
   assign link.rx_active      = i_rx_active;
   assign link.tx_active      = i_tx_active;
   assign link.rx_sof         = i_rx_sof;
   assign link.rx_done        = i_rx_done;

   logic [7:0]                type_a_read;
   logic [7:0]                mirror_read;
   logic [7:0]                watermark_read;
   logic [7:0]                low_field_read;
   logic [SLOT_CNT_WIDTH-1:0] slot_last;

   always_comb begin
      type_a_read    = {2'h0, state_r.type_a_opts};
      mirror_read    = 8'h00;
      mirror_read[RX_START_BIT] = link.rx_start_flag;
      watermark_read = {4'h0, state_r.watermarks};
      low_field_read = 8'h00;
      low_field_read[CLOCK_EXTRACT_OFF_BIT] = state_r.clock_extract_off;
      low_field_read[COLLISION_AVOID_LSB +: 3] = state_r.collision_avoid_level;
      slot_last = state_r.type_a_opts[SLOT_GRID_LONG_BIT] ? SLOT_LONG_LAST : SLOT_SHORT_LAST;
   end

   always_comb begin
      state_nxt = state_r;

      // Enable pin synchroniser
      state_nxt.en_meta = i_en;
      state_nxt.en_sync = state_r.en_meta;
      // RF field code synchroniser
      state_nxt.rf_meta = i_rf_field_code;
      state_nxt.rf_sync = state_r.rf_meta;

      // Register writes, reserved bits dropped
      if (i_reg_wr) begin
         case (i_reg_addr)
            ADDR_TYPE_A_OPTS: begin
               state_nxt.type_a_opts = i_reg_wdata[TYPE_A_WIDTH-1:0];
            end
            ADDR_FIFO_WATERMARKS: begin
               state_nxt.watermarks = i_reg_wdata[WATERMARK_WIDTH-1:0];
            end
            ADDR_LOW_FIELD_LEVEL: begin
               state_nxt.clock_extract_off     = i_reg_wdata[CLOCK_EXTRACT_OFF_BIT];
               state_nxt.collision_avoid_level = i_reg_wdata[COLLISION_AVOID_LSB +: 3];
            end
            default: begin
               state_nxt.type_a_opts = state_r.type_a_opts;
            end
         endcase
      end

      // Enable low holds these two registers at their reset value
      if (!state_r.en_sync) begin
         state_nxt.watermarks            = FIFO_WATERMARKS_RESET[WATERMARK_WIDTH-1:0];
         state_nxt.clock_extract_off     = LOW_FIELD_LEVEL_RESET[CLOCK_EXTRACT_OFF_BIT];
         state_nxt.collision_avoid_level = LOW_FIELD_LEVEL_RESET[COLLISION_AVOID_LSB +: 3];
      end

      // Register reads answer one cycle later
      state_nxt.rvalid = i_reg_rd;
      if (i_reg_rd) begin
         case (i_reg_addr)
            ADDR_TYPE_A_OPTS:     state_nxt.rdata = type_a_read;
            ADDR_RX_START_MIRROR: state_nxt.rdata = mirror_read;
            ADDR_FIFO_WATERMARKS: state_nxt.rdata = watermark_read;
            ADDR_LOW_FIELD_LEVEL: state_nxt.rdata = low_field_read;
            default:              state_nxt.rdata = 8'h00;
         endcase
      end

      // Type A data path
      state_nxt.parity_error = i_rx_parity_err &&
                               !state_r.type_a_opts[PARITY_CHECK_OFF_BIT];
      state_nxt.encoder_bit = state_r.type_a_opts[BITSTREAM_TX_DIRECT_BIT] ?
                              i_bitstream_bit : i_fifo_tx_bit;
      state_nxt.collision_pulses = state_r.type_a_opts[COLLISION_SIX_BIT] ?
                                   COLLISION_PULSES_SIX : COLLISION_PULSES_SEVEN;

      // Low field comparator against the collision-avoidance threshold
      state_nxt.rf_low_above = (state_r.rf_sync >= state_r.collision_avoid_level);
      state_nxt.clock_extract_en = !state_r.clock_extract_off;

      // Next-slot grid timer
      state_nxt.slot_tick = 1'b0;
      if (!i_slot_timer_run) begin
         state_nxt.slot_cnt = '0;
      end else if (state_r.slot_cnt >= slot_last) begin
         state_nxt.slot_cnt  = '0;
         state_nxt.slot_tick = 1'b1;
      end else begin
         state_nxt.slot_cnt = state_r.slot_cnt + 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r                       <= '0;
         state_r.type_a_opts           <= TYPE_A_OPTS_RESET[TYPE_A_WIDTH-1:0];
         state_r.watermarks            <= FIFO_WATERMARKS_RESET[WATERMARK_WIDTH-1:0];
         state_r.clock_extract_off     <= LOW_FIELD_LEVEL_RESET[CLOCK_EXTRACT_OFF_BIT];
         state_r.collision_avoid_level <= LOW_FIELD_LEVEL_RESET[COLLISION_AVOID_LSB +: 3];
         state_r.collision_pulses      <= COLLISION_PULSES_SEVEN;
         state_r.clock_extract_en      <= !LOW_FIELD_LEVEL_RESET[CLOCK_EXTRACT_OFF_BIT];
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs
   assign o_reg_rdata        = state_r.rdata;
   assign o_reg_rvalid       = state_r.rvalid;
   assign o_encoder_bit      = state_r.encoder_bit;
   assign o_parity_error     = state_r.parity_error;
   assign o_parity_check_off = state_r.type_a_opts[PARITY_CHECK_OFF_BIT];
   assign o_bitstream_direct = state_r.type_a_opts[BITSTREAM_TX_DIRECT_BIT];
   assign o_nibble_rx        = state_r.type_a_opts[NIBBLE_RX_BIT];
   assign o_normal_framing   = state_r.type_a_opts[NORMAL_FRAMING_BIT];
   assign o_collision_pulses = state_r.collision_pulses;
   assign o_slot_grid_long   = state_r.type_a_opts[SLOT_GRID_LONG_BIT];
   assign o_slot_tick        = state_r.slot_tick;
   assign o_rx_start_flag    = link.rx_start_flag;
   assign o_rx_done_irq      = link.rx_done_pulse;
   assign o_fifo_irq         = link.fifo_irq;
   assign o_rf_low_above     = state_r.rf_low_above;
   assign o_clock_extract_en = state_r.clock_extract_en;

endmodule : rfid_protocol_option_registers

//--- common/rfid_opt_pkg.sv
// Shared constants and types for the protocol option register bank
package rfid_opt_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_TYPE_A_OPTS    = 8'h10;
   localparam logic [7:0] ADDR_RX_START_MIRROR = 8'h11;
   localparam logic [7:0] ADDR_FIFO_WATERMARKS = 8'h14;
   localparam logic [7:0] ADDR_LOW_FIELD_LEVEL = 8'h16;

   // Type A option field positions
   localparam int PARITY_CHECK_OFF_BIT  = 5;
   localparam int SLOT_GRID_LONG_BIT    = 4;
   localparam int BITSTREAM_TX_DIRECT_BIT = 3;
   localparam int NIBBLE_RX_BIT         = 2;
   localparam int NORMAL_FRAMING_BIT    = 1;
   localparam int COLLISION_SIX_BIT     = 0;
   localparam int TYPE_A_WIDTH          = 6;

   // Receive start mirror position
   localparam int RX_START_BIT = 0;

   // Watermark field positions
   localparam int FIFO_HIGH_LSB = 2;
   localparam int FIFO_LOW_LSB  = 0;
   localparam int WATERMARK_WIDTH = 4;

   // Low field level field positions
   localparam int CLOCK_EXTRACT_OFF_BIT = 7;
   localparam int COLLISION_AVOID_LSB   = 0;

   // Reset values
   localparam logic [7:0] TYPE_A_OPTS_RESET    = 8'h00;
   localparam logic [7:0] FIFO_WATERMARKS_RESET = 8'h00;
   localparam logic [7:0] LOW_FIELD_LEVEL_RESET = 8'h00;

   // FIFO interrupt levels in bytes
   localparam logic [7:0] FIFO_HIGH_LVL0 = 8'h7C;
   localparam logic [7:0] FIFO_HIGH_LVL1 = 8'h78;
   localparam logic [7:0] FIFO_HIGH_LVL2 = 8'h70;
   localparam logic [7:0] FIFO_HIGH_LVL3 = 8'h60;
   localparam logic [7:0] FIFO_LOW_LVL0  = 8'h04;
   localparam logic [7:0] FIFO_LOW_LVL1  = 8'h08;
   localparam logic [7:0] FIFO_LOW_LVL2  = 8'h10;
   localparam logic [7:0] FIFO_LOW_LVL3  = 8'h20;

   // Collision error pulse counts
   localparam logic [2:0] COLLISION_PULSES_SEVEN = 3'h7;
   localparam logic [2:0] COLLISION_PULSES_SIX   = 3'h6;

   // Next-slot grid timing
   localparam int CLK_PERIOD_PS        = 8000;
   localparam int SLOT_GRID_SHORT_PS   = 18880000;
   localparam int SLOT_GRID_LONG_PS    = 37770000;
   localparam int SLOT_GRID_SHORT_CYC  = SLOT_GRID_SHORT_PS / CLK_PERIOD_PS;
   localparam int SLOT_GRID_LONG_CYC   = SLOT_GRID_LONG_PS / CLK_PERIOD_PS;
   localparam int SLOT_CNT_WIDTH       = 13;

   typedef logic [1:0] wm_code_t;
   typedef logic [2:0] ca_level_t;
   typedef logic [7:0] fifo_level_t;

endpackage : rfid_opt_pkg

//--- common/option_link_if.sv
// Signals shared between the option bank and its FIFO and receive helpers
interface option_link_if;
   import rfid_opt_pkg::*;

   wm_code_t    fifo_high_code;
   wm_code_t    fifo_low_code;
   fifo_level_t fifo_level;
   logic        rx_active;
   logic        tx_active;
   logic        fifo_irq;
   logic        rx_sof;
   logic        rx_done;
   logic        rx_start_flag;
   logic        rx_done_pulse;

   modport ctrl (
      output fifo_high_code, fifo_low_code, fifo_level, rx_active, tx_active, rx_sof, rx_done,
      input  fifo_irq, rx_start_flag, rx_done_pulse
   );
   modport wm (
      input  fifo_high_code, fifo_low_code, fifo_level, rx_active, tx_active,
      output fifo_irq
   );
   modport rs (
      input  rx_sof, rx_done,
      output rx_start_flag, rx_done_pulse
   );
endinterface : option_link_if

//--- verilog/fifo_watermark_check.sv
// FIFO fill level comparison against the selected watermarks
module fifo_watermark_check (
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_nrst,
   // Link to the option bank
   option_link_if.wm       link
);
   import rfid_opt_pkg::*;

   typedef struct packed {
      logic fifo_irq;
   } state_t;

   state_t state_r;
   state_t state_nxt;

   function automatic fifo_level_t high_level(input wm_code_t code);
      case (code)
         2'h0:    high_level = FIFO_HIGH_LVL0;
         2'h1:    high_level = FIFO_HIGH_LVL1;
         2'h2:    high_level = FIFO_HIGH_LVL2;
         default: high_level = FIFO_HIGH_LVL3;
      endcase
   endfunction : high_level

   function automatic fifo_level_t low_level(input wm_code_t code);
      case (code)
         2'h0:    low_level = FIFO_LOW_LVL0;
         2'h1:    low_level = FIFO_LOW_LVL1;
         2'h2:    low_level = FIFO_LOW_LVL2;
         default: low_level = FIFO_LOW_LVL3;
      endcase
   endfunction : low_level

   always_comb begin
      state_nxt = state_r;
      state_nxt.fifo_irq =
         (link.rx_active && (link.fifo_level >= high_level(link.fifo_high_code))) ||
         (link.tx_active && (link.fifo_level <= low_level(link.fifo_low_code)));
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign link.fifo_irq = state_r.fifo_irq;

endmodule : fifo_watermark_check

//--- verilog/rx_start_tracker.sv
// Receive-start flag held from start of frame to end of reception
module rx_start_tracker (
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_nrst,
   // Link to the option bank
   option_link_if.rs       link
);
   import rfid_opt_pkg::*;

   typedef struct packed {
      logic rx_start_flag;
      logic rx_done_pulse;
   } state_t;

   state_t state_r;
   state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      // A new start of frame wins over a completion in the same cycle
      if (link.rx_sof) begin
         state_nxt.rx_start_flag = 1'b1;
      end else if (link.rx_done) begin
         state_nxt.rx_start_flag = 1'b0;
      end
      state_nxt.rx_done_pulse = link.rx_done && state_r.rx_start_flag;
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign link.rx_start_flag = state_r.rx_start_flag;
   assign link.rx_done_pulse = state_r.rx_done_pulse;

endmodule : rx_start_tracker

//--- tb/rfid_protocol_option_registers_chk.sv
// Assertion checker for the protocol option register bank
module rfid_protocol_option_registers_chk (
   // Clock and reset
   input wire logic       i_sys_clk,
   input wire logic       i_nrst,
   // Register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       i_reg_wr,
   input wire logic       i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       o_reg_rvalid,
   // Data path and options
   input wire logic       i_rx_parity_err,
   input wire logic       i_bitstream_bit,
   input wire logic       i_fifo_tx_bit,
   input wire logic       o_encoder_bit,
   input wire logic       o_parity_error,
   input wire logic       o_parity_check_off,
   input wire logic       o_bitstream_direct,
   input wire logic [2:0] o_collision_pulses,
   // Receive progress
   input wire logic       i_rx_sof,
   input wire logic       i_rx_done,
   input wire logic       o_rx_start_flag,
   input wire logic       o_rx_done_irq
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_nrst);

   sequence s_wr_opts;
      i_reg_wr && i_reg_addr == 8'h10;
   endsequence
   sequence s_rx_end;
      i_rx_done && o_rx_start_flag;
   endsequence
   property p_coll_count;
      logic six;
      (s_wr_opts, six = i_reg_wdata[0]) ##1 !(i_reg_wr && i_reg_addr == 8'h10)
         |=> o_collision_pulses == (six ? 3'h6 : 3'h7);
   endproperty

   a_rvalid_after_read: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read strobe got no valid pulse");
   a_rvalid_has_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
      else $error("valid pulse without a read");
   a_rdata_holds: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (i_reg_rd && !(i_reg_addr inside {8'h10, 8'h11, 8'h14,
      8'h16}) |=> o_reg_rdata == 8'h00)
      else $error("unmapped read returned nonzero");
   a_parity_gate: assert property (##1 o_parity_error == ($past(i_rx_parity_err) &&
      !$past(o_parity_check_off)))
      else $error("parity error not gated by option");
   a_encoder_select: assert property (##1 o_encoder_bit == ($past(o_bitstream_direct) ?
      $past(i_bitstream_bit) : $past(i_fifo_tx_bit)))
      else $error("encoder source wrong");
   a_collision_count: assert property (p_coll_count)
      else $error("collision pulse count wrong");
   a_rx_flag_set: assert property (i_rx_sof |=> o_rx_start_flag)
      else $error("start flag not set");
   a_rx_flag_clear: assert property (i_rx_done && !i_rx_sof |=> !o_rx_start_flag)
      else $error("start flag not cleared");
   a_rx_done_irq: assert property (s_rx_end |=> o_rx_done_irq ##1 !o_rx_done_irq)
      else $error("completion pulse wrong");
   a_irq_has_cause: assert property (o_rx_done_irq |-> $past(i_rx_done) &&
      $past(o_rx_start_flag))
      else $error("completion pulse without cause");
endmodule : rfid_protocol_option_registers_chk

bind rfid_protocol_option_registers rfid_protocol_option_registers_chk u_chk (
   .i_sys_clk, .i_nrst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
   .o_reg_rvalid, .i_rx_parity_err, .i_bitstream_bit, .i_fifo_tx_bit, .o_encoder_bit,
   .o_parity_error, .o_parity_check_off, .o_bitstream_direct, .o_collision_pulses,
   .i_rx_sof, .i_rx_done, .o_rx_start_flag, .o_rx_done_irq
);

//--- tb/test_rfid_protocol_option_registers.sv
// Self-checking bench for the protocol option register bank
module test_rfid_protocol_option_registers;
   timeunit 1ns;
   timeprecision 1ps;
   import rfid_opt_pkg::*;

   logic        i_sys_clk, i_nrst, i_en, i_reg_wr, i_reg_rd, i_rx_parity_err;
   logic        i_bitstream_bit, i_fifo_tx_bit, i_slot_timer_run, i_rx_sof, i_rx_done;
   logic        i_rx_active, i_tx_active;
   logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata;
   fifo_level_t i_fifo_level;
   ca_level_t   i_rf_field_code;
   logic        o_reg_rvalid, o_encoder_bit, o_parity_error, o_parity_check_off;
   logic        o_bitstream_direct, o_nibble_rx, o_normal_framing, o_slot_grid_long;
   logic        o_slot_tick, o_rx_start_flag, o_rx_done_irq, o_fifo_irq;
   logic        o_rf_low_above, o_clock_extract_en;
   logic [2:0]  o_collision_pulses;
   int          err_count, checks_done, cycles, ticks;
   int          hi_lvl [4] = '{124, 120, 112, 96};
   int          lo_lvl [4] = '{4, 8, 16, 32};
   integer      seed = 32'h0E2C7EF1;
   logic [7:0]  d, e, w;

   rfid_protocol_option_registers #(.SLOT_SHORT_CYCLES(5), .SLOT_LONG_CYCLES(9)) u_dut (
      .i_sys_clk, .i_nrst, .i_en, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
      .o_reg_rdata, .o_reg_rvalid, .i_rx_parity_err, .i_bitstream_bit, .i_fifo_tx_bit,
      .o_encoder_bit, .o_parity_error, .o_parity_check_off, .o_bitstream_direct,
      .o_nibble_rx, .o_normal_framing, .o_collision_pulses, .i_slot_timer_run,
      .o_slot_grid_long, .o_slot_tick, .i_rx_sof, .i_rx_done, .o_rx_start_flag,
      .o_rx_done_irq, .i_fifo_level, .i_rx_active, .i_tx_active, .o_fifo_irq,
      .i_rf_field_code, .o_rf_low_above, .o_clock_extract_en
   );

   initial begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge i_sys_clk);
      i_reg_addr = a;
      i_reg_wdata = v;
      i_reg_wr = 1'b1;
      @(negedge i_sys_clk);
      i_reg_wr = 1'b0;
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge i_sys_clk);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      @(negedge i_sys_clk);
      i_reg_rd = 1'b0;
      chk("read valid", 8'h01, {7'h00, o_reg_rvalid});
      chk($sformatf("register %h", a), exp, o_reg_rdata);
   endtask : rdchk

   function automatic logic fifo_exp(logic [3:0] wm, logic [7:0] lvl, logic rx, logic tx);
      return (rx && lvl >= hi_lvl[wm[3:2]]) || (tx && lvl <= lo_lvl[wm[1:0]]);
   endfunction : fifo_exp

   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude

   // Cuts a hang short
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         conclude();
      end
   end

   initial begin
      {i_nrst, i_en, i_reg_wr, i_reg_rd, i_rx_parity_err, i_bitstream_bit} = '0;
      {i_fifo_tx_bit, i_slot_timer_run, i_rx_sof, i_rx_done, i_rx_active, i_tx_active} = '0;
      i_reg_addr = 8'h00;
      i_reg_wdata = 8'h00;
      i_fifo_level = 8'h00;
      i_rf_field_code = 3'h0;
      repeat (4) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      i_nrst = 1'b1;
      foreach (hi_lvl[k]) rdchk(8'h10 + 8'(k == 0 ? 0 : k == 1 ? 1 : k * 2), 8'h00);
      chk("collision pulses", 8'h07, 8'(o_collision_pulses));
      chk("clock extract", 8'h01, 8'(o_clock_extract_en));
      $display("test reset done");

      i_en = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      for (int k = 0; k < 16; k++) begin
         d = $random(seed);
         i_rf_field_code = ca_level_t'($random(seed));
         wr(8'h10, d);
         chk("parity off", 8'(d[5]), 8'(o_parity_check_off));
         chk("slot grid", 8'(d[4]), 8'(o_slot_grid_long));
         chk("direct tx", 8'(d[3]), 8'(o_bitstream_direct));
         chk("nibble rx", 8'(d[2]), 8'(o_nibble_rx));
         chk("framing", 8'(d[1]), 8'(o_normal_framing));
         repeat (4) begin
            e = $random(seed);
            i_rx_parity_err = e[0];
            i_bitstream_bit = e[1];
            i_fifo_tx_bit = e[2];
            @(negedge i_sys_clk);
            chk("parity error", 8'(e[0] & ~d[5]), 8'(o_parity_error));
            chk("encoder bit", 8'(d[3] ? e[1] : e[2]), 8'(o_encoder_bit));
         end
         chk("collision pulses", d[0] ? 8'h06 : 8'h07, 8'(o_collision_pulses));
         wr(8'h14, d);
         wr(8'h16, d);
         wr(8'h11, d);
         wr(8'h3F, d);
         rdchk(8'h10, d & 8'h3F);
         rdchk(8'h11, 8'h00);
         rdchk(8'h14, d & 8'h0F);
         rdchk(8'h16, d & 8'h87);
         rdchk(8'h3F, 8'h00);
         chk("clock extract", {7'h00, !d[7]}, 8'(o_clock_extract_en));
         chk("rf low", 8'(i_rf_field_code >= d[2:0]), 8'(o_rf_low_above));
      end
      $display("test registers done");

      @(negedge i_sys_clk);
      i_rx_sof = 1'b1;
      @(negedge i_sys_clk);
      i_rx_sof = 1'b0;
      chk("start flag", 8'h01, 8'(o_rx_start_flag));
      rdchk(8'h11, 8'h01);
      repeat (2) @(negedge i_sys_clk);
      i_rx_done = 1'b1;
      @(negedge i_sys_clk);
      i_rx_done = 1'b0;
      chk("done irq", 8'h01, 8'(o_rx_done_irq));
      chk("start flag", 8'h00, 8'(o_rx_start_flag));
      @(negedge i_sys_clk);
      chk("done irq", 8'h00, 8'(o_rx_done_irq));
      i_rx_done = 1'b1;
      @(negedge i_sys_clk);
      i_rx_done = 1'b0;
      chk("done irq", 8'h00, 8'(o_rx_done_irq));
      rdchk(8'h11, 8'h00);
      d = d | 8'h02;
      wr(8'h10, d);
      chk("framing", 8'h01, 8'(o_normal_framing));
      $display("test receive done");

      for (int c = 0; c < 4; c++) begin
         e = $random(seed);
         w = 8'(c * 4) | (e & 8'h03);
         wr(8'h14, w);
         for (int j = 0; j < 8; j++) begin
            e = $random(seed);
            i_rx_active = (j < 2) ? 1'b1 : (j < 4) ? 1'b0 : e[0];
            i_tx_active = (j < 2) ? 1'b0 : (j < 4) ? 1'b1 : e[1];
            i_fifo_level = (j == 0) ? 8'(hi_lvl[c]) : (j == 1) ? 8'(hi_lvl[c] - 1) :
               (j == 2) ? 8'(lo_lvl[w[1:0]]) : (j == 3) ? 8'(lo_lvl[w[1:0]] + 1) : e;
            @(negedge i_sys_clk);
            chk("fifo irq", 8'(fifo_exp(w[3:0], i_fifo_level, i_rx_active, i_tx_active)),
               8'(o_fifo_irq));
         end
      end
      {i_rx_active, i_tx_active} = 2'b00;
      $display("test fifo levels done");

      i_en = 1'b0;
      repeat (4) @(negedge i_sys_clk);
      rdchk(8'h14, 8'h00);
      rdchk(8'h16, 8'h00);
      wr(8'h14, 8'hFF);
      rdchk(8'h14, 8'h00);
      rdchk(8'h10, d & 8'h3F);
      i_en = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      wr(8'h14, 8'h0A);
      rdchk(8'h14, 8'h0A);
      $display("test enable done");

      for (int g = 0; g < 2; g++) begin
         wr(8'h10, 8'(g * 16));
         i_slot_timer_run = 1'b1;
         ticks = 0;
         repeat (37) begin
            @(negedge i_sys_clk);
            ticks += int'(o_slot_tick);
         end
         i_slot_timer_run = 1'b0;
         chk("slot ticks", g ? 8'h04 : 8'h07, 8'(ticks));
      end
      $display("test slot grid done");
      conclude();
   end
endmodule : test_rfid_protocol_option_registers
